// [hdl/uart_rx_err_defs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with an 8-bit byte address
`ifndef UART_RX_ERR_DEFS_SVH
`define UART_RX_ERR_DEFS_SVH

`define OFS_CTRL      8'h00
`define OFS_BITDIV    8'h04
`define OFS_STATUS    8'h08
`define OFS_DATA      8'h0C
`define OFS_INT_STAT  8'h10
`define OFS_INT_MASK  8'h14

`define CTRL_RX_EN    0
`define CTRL_TWO_STOP 1
`define CTRL_STANDBY  2

`define STAT_FULL     6
`define STAT_OVR      5
`define STAT_FER      4

`define IRQ_DONE      0
`define IRQ_OVR       1
`define IRQ_FER       2

`define CTRL_RST      3'h0
`define IMASK_RST     3'h0
`define BIT_NS        8680
`define CLK_NS        100
`define BITDIV_RST    16'h0056

`endif

// [hdl/uart_rx_err_pkg.sv]
// types shared by the receive channel: receiver states and the state record
// assumes uart_rx_err_defs.svh is visible to the files that use it
package uart_rx_err_pkg;

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_START = 5'h02,
		S_DATA  = 5'h04,
		S_STOP1 = 5'h08,
		S_STOP2 = 5'h10
	} rx_state_t;

	typedef struct packed {
		rx_state_t   state;
		logic [15:0] timer;
		logic [2:0]  bitn;
		logic [7:0]  shift;
		logic        full;
		logic        ovr;
		logic        framing_flag;
		logic        full_seen;
		logic        ovr_seen;
		logic        fer_seen;
		logic        rx_en;
		logic        two_stop;
		logic        standby;
		logic [15:0] div;
		logic [2:0]  ist;
		logic [2:0]  imask;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        rx_s1;
		logic        rx_s2;
	} chan_state_t;

endpackage

// [hdl/rx_hold_buffer.sv]
// receive data buffer: one byte written by the receiver, read by software
// assumes the same clock, reset and clock enable as the channel around it
`timescale 1ns/10ps
module rx_hold_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             pce,
	input  wire logic             we,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata
);

	// read data come straight from the storage flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else if (pce && we) begin
			rdata <= wdata;
		end
	end

endmodule

// [hdl/uart_rx_err.sv]
// serial receive channel with overrun and framing flags behind an apb slave
// assumes rxd is an asynchronous pin and pclk runs at 10 MHz
//
// Functional notes
// - status holds the overrun flag at bit 5 and the framing flag at bit 4.
// - overrun flag resets to 0, clears in standby, or by writing 0 after reading it as 1.
// - framing flag resets to 0, clears in standby, or by writing 0 after reading it as 1.
// - clearing the receive enable bit leaves both flags as they were.
// - on overrun the buffer keeps the earlier byte and the new byte is dropped.
// - no reception is started while the overrun flag is set.
// - with two stop bits only the first is checked, the second is ignored.
// - on a framing error the byte still goes to the buffer but the full flag stays clear.
// - no reception is started while the framing flag is set.
// - a stop bit sampled as 0 sets the framing flag.
`timescale 1ns/10ps
`include "uart_rx_err_defs.svh"
module uart_rx_err (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        rxd,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);

	uart_rx_err_pkg::chan_state_t st_reg;
	uart_rx_err_pkg::chan_state_t st_next;

	logic       setup;
	logic       acc;
	logic       wr_stat;
	logic       rx_ok;
	logic       tick;
	logic       ev_done;
	logic       ev_ovr;
	logic       ev_fer;
	logic       buf_we;
	logic [7:0] buf_q;

	rx_hold_buffer #(
		.WIDTH(8)
	) u_buf (
		.pclk   (pclk),
		.presetn(presetn),
		.pce    (pce),
		.we     (buf_we),
		.wdata  (st_next.shift),
		.rdata  (buf_q)
	);

	// next state of the whole channel
	always_comb begin
		st_next = st_reg;
		buf_we  = 1'b0;
		ev_done = 1'b0;
		ev_ovr  = 1'b0;
		ev_fer  = 1'b0;
		// two flops before the pin is looked at
		st_next.rx_s1 = rxd;
		st_next.rx_s2 = st_reg.rx_s1;
		setup   = psel && !penable;
		acc     = psel && penable && st_reg.pready;
		wr_stat = acc && pwrite && paddr == `OFS_STATUS;
		tick    = st_reg.timer == 16'h0000;
		rx_ok   = st_reg.rx_en && !st_reg.standby && !st_reg.ovr && !st_reg.framing_flag;

		// apb: answer one cycle after setup, so every access takes two cycles
		st_next.pready  = setup;
		st_next.pslverr = 1'b0;
		if (setup) begin
			st_next.prdata = 32'h0000_0000;
			case (paddr)
				`OFS_CTRL: begin
					st_next.prdata[`CTRL_RX_EN]    = st_reg.rx_en;
					st_next.prdata[`CTRL_TWO_STOP] = st_reg.two_stop;
					st_next.prdata[`CTRL_STANDBY]  = st_reg.standby;
				end
				`OFS_BITDIV: st_next.prdata[15:0] = st_reg.div;
				`OFS_STATUS: begin
					st_next.prdata[`STAT_FULL] = st_reg.full;
					st_next.prdata[`STAT_OVR]  = st_reg.ovr;
					st_next.prdata[`STAT_FER]  = st_reg.framing_flag;
				end
				`OFS_DATA:     st_next.prdata[7:0] = buf_q;
				`OFS_INT_STAT: st_next.prdata[2:0] = st_reg.ist;
				`OFS_INT_MASK: st_next.prdata[2:0] = st_reg.imask;
				default:       st_next.pslverr = 1'b1;
			endcase
		end

		// a flag read as 1 arms its clear-by-zero
		if (acc && !pwrite && paddr == `OFS_STATUS) begin
			st_next.full_seen = st_reg.full_seen | st_reg.prdata[`STAT_FULL];
			st_next.ovr_seen  = st_reg.ovr_seen | st_reg.prdata[`STAT_OVR];
			st_next.fer_seen  = st_reg.fer_seen | st_reg.prdata[`STAT_FER];
		end

		// register writes take effect on the completing edge only
		if (acc && pwrite) begin
			case (paddr)
				`OFS_CTRL: begin
					st_next.rx_en    = pwdata[`CTRL_RX_EN];
					st_next.two_stop = pwdata[`CTRL_TWO_STOP];
					st_next.standby  = pwdata[`CTRL_STANDBY];
				end
				`OFS_BITDIV:   st_next.div = pwdata[15:0];
				`OFS_INT_STAT: st_next.ist = st_reg.ist & ~pwdata[2:0];
				`OFS_INT_MASK: st_next.imask = pwdata[2:0];
				default: ;
			endcase
		end

		if (wr_stat) begin
			if (!pwdata[`STAT_FULL] && st_reg.full_seen) begin
				st_next.full = 1'b0;
			end
			if (!pwdata[`STAT_OVR] && st_reg.ovr_seen) begin
				st_next.ovr = 1'b0;
			end
			if (!pwdata[`STAT_FER] && st_reg.fer_seen) begin
				st_next.framing_flag = 1'b0;
			end
		end

		// receiver: bit timer counts down to zero in every state, idle included
		if (!tick) begin
			st_next.timer = st_reg.timer - 16'h0001;
		end
		case (st_reg.state)
			uart_rx_err_pkg::S_IDLE: begin
				if (rx_ok && !st_reg.rx_s2) begin
					st_next.state = uart_rx_err_pkg::S_START;
					st_next.timer = {1'b0, st_reg.div[15:1]};
				end
			end
			uart_rx_err_pkg::S_START: begin
				if (tick) begin
					// a glitch shorter than half a bit is dropped
					st_next.state = st_reg.rx_s2 ? uart_rx_err_pkg::S_IDLE : uart_rx_err_pkg::S_DATA;
					st_next.timer = st_reg.div;
					st_next.bitn  = 3'h0;
				end
			end
			uart_rx_err_pkg::S_DATA: begin
				if (tick) begin
					st_next.shift = {st_reg.rx_s2, st_reg.shift[7:1]};
					st_next.timer = st_reg.div;
					st_next.bitn  = st_reg.bitn + 3'h1;
					if (st_reg.bitn == 3'h7) begin
						st_next.state = uart_rx_err_pkg::S_STOP1;
					end
				end
			end
			uart_rx_err_pkg::S_STOP1: begin
				// a stop sample in the cycle that a disable lands is dropped, so flags keep their value
				if (tick && st_reg.rx_en && !st_reg.standby) begin
					ev_done = 1'b1;
					ev_fer  = !st_reg.rx_s2;
					ev_ovr  = st_reg.full;
					buf_we  = !st_reg.full;
					if (!st_reg.full && st_reg.rx_s2) begin
						st_next.full = 1'b1;
					end
					st_next.state = st_reg.two_stop ? uart_rx_err_pkg::S_STOP2 : uart_rx_err_pkg::S_IDLE;
					st_next.timer = st_reg.div;
				end
			end
			uart_rx_err_pkg::S_STOP2: begin
				if (tick) begin
					st_next.state = uart_rx_err_pkg::S_IDLE;
				end
			end
			default: st_next.state = uart_rx_err_pkg::S_IDLE;
		endcase

		// events set after the clears, so a set in the clearing cycle wins
		if (ev_ovr) begin
			st_next.ovr = 1'b1;
		end
		if (ev_fer) begin
			st_next.framing_flag = 1'b1;
		end
		st_next.ist = st_next.ist | {ev_fer, ev_ovr, ev_done};

		if (!st_reg.rx_en || st_reg.standby) begin
			st_next.state = uart_rx_err_pkg::S_IDLE;
			buf_we        = 1'b0;
		end
		if (st_reg.standby) begin
			st_next.full = 1'b0;
			st_next.ovr  = 1'b0;
			st_next.framing_flag  = 1'b0;
		end
		// a cleared flag must be read as 1 again before the next clear
		if (!st_next.full) begin
			st_next.full_seen = 1'b0;
		end
		if (!st_next.ovr) begin
			st_next.ovr_seen = 1'b0;
		end
		if (!st_next.framing_flag) begin
			st_next.fer_seen = 1'b0;
		end
		st_next.irq = |(st_next.ist & st_next.imask);
	end

	// all state but the buffer byte in u_buf in one record; low clock enable freezes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.state    <= uart_rx_err_pkg::S_IDLE;
			st_reg.div      <= `BITDIV_RST;
			st_reg.imask    <= `IMASK_RST;
			st_reg.rx_s1    <= 1'b1;
			st_reg.rx_s2    <= 1'b1;
			st_reg.rx_en    <= 1'b0;
			st_reg.two_stop <= 1'b0;
			st_reg.standby  <= 1'b0;
		end else if (pce) begin
			st_reg <= st_next;
		end
	end

	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign irq     = st_reg.irq;

	// flag positions, as the flags stood at setup
	property p_stat_layout;
		@(posedge pclk) disable iff (!presetn)
		(pce && setup && paddr == `OFS_STATUS)
		|=> (prdata[5] == $past(st_reg.ovr)) && (prdata[4] == $past(st_reg.framing_flag));
	endproperty
	a_stat_layout: assert property (p_stat_layout) else $error("status flag layout wrong");

	property p_standby_clear;
		@(posedge pclk) disable iff (!presetn)
		(pce && st_reg.standby) |=> !st_reg.ovr && !st_reg.framing_flag;
	endproperty
	a_standby_clear: assert property (p_standby_clear) else $error("standby left a flag set");

	property p_fer_clear;
		@(posedge pclk) disable iff (!presetn)
		(pce && wr_stat && !pwdata[4] && st_reg.fer_seen && !ev_fer) |=> !st_reg.framing_flag;
	endproperty
	a_fer_clear: assert property (p_fer_clear) else $error("framing flag not cleared");

	property p_disable_keeps;
		@(posedge pclk) disable iff (!presetn)
		(pce && !st_reg.rx_en && !st_reg.standby && !wr_stat) |=> $stable(st_reg.ovr) && $stable(st_reg.framing_flag);
	endproperty
	a_disable_keeps: assert property (p_disable_keeps) else $error("flags moved while disabled");

	property p_ovr_drop;
		@(posedge pclk) disable iff (!presetn)
		(pce && ev_done && st_reg.full) |-> !buf_we ##1 st_reg.ovr;
	endproperty
	a_ovr_drop: assert property (p_ovr_drop) else $error("overrun byte reached the buffer");

	property p_ovr_halt;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.ovr && st_reg.state == uart_rx_err_pkg::S_IDLE) |=> st_reg.state == uart_rx_err_pkg::S_IDLE;
	endproperty
	a_ovr_halt: assert property (p_ovr_halt) else $error("reception started under overrun");

	property p_fer_halt;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.framing_flag && st_reg.state == uart_rx_err_pkg::S_IDLE) |=> st_reg.state == uart_rx_err_pkg::S_IDLE;
	endproperty
	a_fer_halt: assert property (p_fer_halt) else $error("reception started under framing error");

	property p_stop2_ignored;
		@(posedge pclk) disable iff (!presetn)
		(pce && st_reg.state == uart_rx_err_pkg::S_STOP2 && tick && !st_reg.framing_flag && st_reg.rx_en && !st_reg.standby)
		|=> !st_reg.framing_flag && st_reg.state == uart_rx_err_pkg::S_IDLE;
	endproperty
	a_stop2_ignored: assert property (p_stop2_ignored) else $error("second stop bit was checked");

	property p_fer_load;
		@(posedge pclk) disable iff (!presetn)
		(pce && ev_fer && !st_reg.full && st_reg.rx_en && !st_reg.standby)
		|-> buf_we ##1 (st_reg.framing_flag && !st_reg.full);
	endproperty
	a_fer_load: assert property (p_fer_load) else $error("framing error byte handling wrong");

	property p_fer_set;
		@(posedge pclk) disable iff (!presetn)
		(pce && st_reg.state == uart_rx_err_pkg::S_STOP1 && tick && !st_reg.rx_s2 && st_reg.rx_en && !st_reg.standby)
		|=> st_reg.framing_flag;
	endproperty
	a_fer_set: assert property (p_fer_set) else $error("low stop bit did not set framing flag");

	property p_ovr_set;
		@(posedge pclk) disable iff (!presetn)
		(pce && st_reg.state == uart_rx_err_pkg::S_STOP1 && tick && st_reg.full && st_reg.rx_en && !st_reg.standby)
		|=> st_reg.ovr;
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged on a full buffer");

	// interrupt follows an unmasked event unless the mask is being rewritten
	property p_irq_event;
		@(posedge pclk) disable iff (!presetn)
		(pce && !(acc && pwrite && paddr == `OFS_INT_MASK) && |({ev_fer, ev_ovr, ev_done} & st_reg.imask)) |=> irq;
	endproperty
	a_irq_event: assert property (p_irq_event) else $error("unmasked event did not raise the interrupt");

	// apb answers one cycle after every setup
	property p_ready_one;
		@(posedge pclk) disable iff (!presetn)
		(pce && setup) |=> pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("apb answer missing after setup");

	// unmapped offsets answer with an error and read as zero
	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(pce && setup && paddr > `OFS_INT_MASK) |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped offset answered without error");

endmodule

// [sim/serial_tx_model.sv]
// remote serial transmitter driving the receive pin of the channel
// assumes one pclk domain; bit time is given in pclk cycles per call
`timescale 1ns/10ps
module serial_tx_model (
	input  wire logic pclk,
	output logic      rxd
);
	// line idles high between frames
	initial rxd = 1'b1;

	// start bit, 8 data bits lsb first, one or two stop bits, then an idle bit
	task automatic send(input logic [7:0] d, input logic s1, input logic s2, input int two, input int nbit);
		logic [10:0] fr;
		int          n;
		fr = {s2, s1, d, 1'b0};
		n = two ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rxd <= fr[i];
			repeat (nbit - 1) @(posedge pclk);
		end
		@(posedge pclk);
		rxd <= 1'b1;
		repeat (nbit) @(posedge pclk);
	endtask
endmodule

// [sim/uart_rx_err_tb.sv]
// self-checking bench for the receive channel error flags
// assumes the apb slave answers in one access cycle and bitdiv set to 15
`timescale 1ns/10ps
`include "uart_rx_err_defs.svh"
module uart_rx_err_tb;
	logic        pclk, presetn, pce, psel, penable, pwrite, rxd, pready, pslverr, irq;
	logic [7:0]  paddr, b;
	logic [31:0] pwdata, prdata, rv, perr;
	int          fails, checked, cyc, st, dat;

	uart_rx_err dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rxd(rxd), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));
	serial_tx_model tx (.pclk(pclk), .rxd(rxd));

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// hang guard, far above the roughly 1600 cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is seen at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		perr = {31'h0000_0000, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 0);
		check(rv, exp);
	endtask

	// reference receiver: status bit 6 full, bit 5 overrun, bit 4 framing
	task model(input logic [7:0] d, input logic s1);
		if ((st & 8'h30) != 0) return;
		if (st[6]) begin
			st[5] = 1;
			if (!s1) st[4] = 1;
		end else begin
			dat = d;
			if (s1) st[6] = 1;
			else st[4] = 1;
		end
	endtask

	task frame(input logic s1, input logic s2, input int two);
		b = 8'($urandom);
		tx.send(b, s1, s2, two, 16);
		model(b, s1);
		rdc(`OFS_STATUS, st);
		rdc(`OFS_DATA, dat);
	endtask

	// read then write 0 clears whatever read as 1
	task clr;
		apb(1'b0, `OFS_STATUS, 0);
		apb(1'b1, `OFS_STATUS, 0);
		st = 0;
	endtask

	task tend(input string s);
		$display("test %s done", s);
	endtask

	task stop_test;
		$display("compared %0d, failed %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// main sequence
	initial begin
		presetn = 1'b0; pce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0000_0000; fails = 0; checked = 0; cyc = 0; st = 0; dat = 0;
		void'($urandom(84229));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`OFS_STATUS, 0);
		rdc(`OFS_CTRL, 0);
		rdc(`OFS_BITDIV, 32'h0000_0056);
		rdc(`OFS_INT_MASK, 0);
		apb(1'b0, 8'h18, 0);
		check(perr, 1);
		check(rv, 0);
		tend("reset");
		apb(1'b1, `OFS_BITDIV, 15);
		apb(1'b1, `OFS_INT_MASK, 7);
		apb(1'b1, `OFS_CTRL, 1);
		frame(1, 1, 0);
		check(32'(irq), 1);
		apb(1'b1, `OFS_INT_MASK, 0);
		rdc(`OFS_INT_STAT, 1);
		check(32'(irq), 0);
		apb(1'b1, `OFS_INT_STAT, 7);
		apb(1'b1, `OFS_INT_MASK, 7);
		rdc(`OFS_INT_STAT, 0);
		check(32'(irq), 0);
		tend("irq");
		frame(1, 1, 0);
		frame(1, 1, 0);
		clr();
		rdc(`OFS_STATUS, 0);
		tend("overrun");
		frame(0, 1, 0);
		frame(1, 1, 0);
		apb(1'b1, `OFS_CTRL, 0);
		rdc(`OFS_STATUS, st);
		apb(1'b1, `OFS_CTRL, 4);
		st = 0;
		rdc(`OFS_STATUS, 0);
		apb(1'b1, `OFS_CTRL, 1);
		frame(0, 1, 0);
		clr();
		rdc(`OFS_STATUS, 0);
		tend("framing");
		apb(1'b1, `OFS_CTRL, 3);
		frame(1, 0, 1);
		clr();
		frame(0, 1, 1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		st = 0;
		rdc(`OFS_STATUS, 0);
		tend("two stop and reset");
		stop_test();
	end
endmodule
